// *** verilog/wrw_pkg.sv ***
// shared constants and types of the windowed reset watchdog
// assumes a 100 MHz clock_in and a 32-bit AXI4-Lite register bus
package wrw_pkg;

   // ==========================================================
   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int STRB_LANE0 = 0;
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // control register layout
   localparam int CTRL_W = 8;
   localparam int CNT_W = 7;
   localparam int ACT_BIT = 7;
   localparam int TOP_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h7f;
   localparam logic [6:0] ROLL_FROM = 7'h40;
   localparam logic [6:0] CNT_ONE = 7'h01;

   // ==========================================================
   // status register layout
   localparam int ST_W = 4;
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_PULSE_BIT = 1;
   localparam int ST_HW_OPT_BIT = 2;
   localparam int ST_HALT_OPT_BIT = 3;

   // ==========================================================
   // option straps
   localparam int OPT_N = 2;
   localparam int OPT_HW = 0;
   localparam int OPT_HALT = 1;

   // ==========================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int PRESCALE_DEFAULT = 16384;
   localparam int PRESC_W = 15;
   localparam int PULSE_NS = 30000;
   localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_W = 12;

   // ==========================================================
   // bus channel states
   typedef enum logic [1:0] {
      WS_COLLECT = 2'h0,
      WS_RESP = 2'h1
   } wrw_wr_state_t;

   typedef enum logic [1:0] {
      RS_IDLE = 2'h0,
      RS_DATA = 2'h1
   } wrw_rd_state_t;

endpackage

// *** verilog/wrw_pulse_gen.sv ***
// reset pulse timer of the watchdog
// assumes start_in comes from logic on clock_in
`timescale 1ns/1ps

module wrw_pulse_gen (
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // request
   input wire logic start_in,
   // pulse state
   output logic busy_out
);

   // ==========================================================
   // state
   typedef struct packed {
      logic busy;
      logic [wrw_pkg::PULSE_W-1:0] count;
   } wrw_pulse_state_t;

   localparam logic [wrw_pkg::PULSE_W-1:0] LAST_COUNT =
      wrw_pkg::PULSE_W'(wrw_pkg::PULSE_CYCLES - 1);

   wrw_pulse_state_t state_reg;
   wrw_pulse_state_t state_next;

   // ==========================================================
   // pulse of fixed length, new starts ignored while busy
   always_comb begin
      state_next = state_reg;
      if (state_reg.busy) begin
         if (state_reg.count == LAST_COUNT) begin
            state_next.busy = 1'b0;
            state_next.count = '0;
         end else begin
            state_next.count = state_reg.count + 1'b1;
         end
      end else if (start_in) begin
         state_next.busy = 1'b1;
         state_next.count = '0;
      end
   end

   // state register, frozen while ce_in is low
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_reg <= '0;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   assign busy_out = state_reg.busy;

endmodule // wrw_pulse_gen

// *** verilog/wrw_top.sv ***
// windowed reset watchdog: free-running down-counter, prescaler,
// reset pulse generation and an AXI4-Lite register slave
// assumes AXI4-Lite master and halt_in on clock_in; option straps
// arrive from outside the clock domain
// all outputs are registered; ce_in low freezes every flip-flop
//
// Functional notes
// - counter decrements every 16384 prescaler cycles
// - six low bits set 64 timeout steps
// - active and 40h to 3Fh starts reset pulse
// - counter keeps counting while watchdog inactive
// - control writes leave prescaler phase untouched
// - watchdog inactive after every reset
// - once active, only reset deactivates
// - activation with top bit clear resets at once
// - halt while active generates a reset
// - option strap selects reset on halt
// - option strap selects hardware watchdog mode
// - hardware mode: always active, activation ignored
// - control holds activation bit7, counter 6:0, 7Fh
// - software sets activation, only reset clears
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module wrw_top #(
   parameter int PRESCALE_CYCLES = wrw_pkg::PRESCALE_DEFAULT
) (
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // axi4-lite write address
   input wire logic [wrw_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   // axi4-lite write data
   input wire logic [wrw_pkg::DATA_W-1:0] s_axi_wdata_in,
   input wire logic [wrw_pkg::STRB_W-1:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read address
   input wire logic [wrw_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   // axi4-lite read data
   output logic [wrw_pkg::DATA_W-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // cpu and option straps
   input wire logic halt_in,
   input wire logic hw_watchdog_opt_in,
   input wire logic halt_reset_option_in,
   // chip reset request
   output logic wdg_reset_n_out
);

   // ==========================================================
   // state
   typedef struct packed {
      // bus channel states and captures
      wrw_pkg::wrw_wr_state_t wr_state;
      wrw_pkg::wrw_rd_state_t rd_state;
      logic aw_have;
      logic [wrw_pkg::ADDR_W-1:0] waddr;
      logic w_have;
      logic [wrw_pkg::DATA_W-1:0] wdata;
      logic [wrw_pkg::STRB_W-1:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [wrw_pkg::DATA_W-1:0] rdata;
      logic [1:0] rresp;
      // option strap synchroniser
      logic [wrw_pkg::OPT_N-1:0] opt_meta;
      logic [wrw_pkg::OPT_N-1:0] opt_sync;
      // watchdog core
      logic [wrw_pkg::PRESC_W-1:0] presc;
      logic activation_bit;
      logic [wrw_pkg::CNT_W-1:0] counter;
      // pin register
      logic reset_n;
   } wrw_state_t;

   // reset image: inactive, counter at top, pin released
   // every other field, bus state included, starts at zero
   localparam wrw_state_t STATE_RESET = '{
      wr_state: wrw_pkg::WS_COLLECT,
      rd_state: wrw_pkg::RS_IDLE,
      activation_bit: wrw_pkg::CTRL_RESET[wrw_pkg::ACT_BIT],
      counter: wrw_pkg::CTRL_RESET[wrw_pkg::CNT_W-1:0],
      reset_n: 1'b1,
      default: '0
   };

   // last prescaler count of one period
   // the parameter must not exceed two to the prescaler width
   localparam logic [wrw_pkg::PRESC_W-1:0] PRESC_LAST =
      wrw_pkg::PRESC_W'(PRESCALE_CYCLES - 1);

   wrw_state_t state_reg;
   wrw_state_t state_next;

   // ==========================================================
   // combinational helpers
   // only ctrl_write and read_word are set at the top of their process; pulse_busy comes from u_pulse
   logic presc_tick;
   logic ctrl_write;
   logic eff_active;
   logic fire;
   logic pulse_busy;
   logic [wrw_pkg::DATA_W-1:0] read_word;

   // ==========================================================
   // address decode, used by both channels
   // only aligned words at the two mapped offsets hit; all
   // other addresses answer with an error and change nothing
   function automatic logic reg_hit(input logic [wrw_pkg::ADDR_W-1:0] addr);
      reg_hit = (addr == wrw_pkg::CTRL_OFFSET) ||
                (addr == wrw_pkg::STATUS_OFFSET);
   endfunction

   // status word from the watchdog's own state
   function automatic logic [wrw_pkg::ST_W-1:0] status_bits(
      input logic active,
      input logic busy,
      input logic [wrw_pkg::OPT_N-1:0] opts
   );
      logic [wrw_pkg::ST_W-1:0] bits;
      bits = '0;
      bits[wrw_pkg::ST_ACTIVE_BIT] = active;
      bits[wrw_pkg::ST_PULSE_BIT] = busy;
      bits[wrw_pkg::ST_HW_OPT_BIT] = opts[wrw_pkg::OPT_HW];
      bits[wrw_pkg::ST_HALT_OPT_BIT] = opts[wrw_pkg::OPT_HALT];
      status_bits = bits;
   endfunction

   // ==========================================================
   // read data mux, unmapped and reserved bits read as zero
   // muxed from the address pins, captured when ar is taken
   always_comb begin
      read_word = '0;
      if (s_axi_araddr_in == wrw_pkg::CTRL_OFFSET) begin
         read_word = wrw_pkg::DATA_W'({state_reg.activation_bit,
                                       state_reg.counter});
      end else if (s_axi_araddr_in == wrw_pkg::STATUS_OFFSET) begin
         read_word = wrw_pkg::DATA_W'(status_bits(
            state_reg.activation_bit | state_reg.opt_sync[wrw_pkg::OPT_HW],
            pulse_busy, state_reg.opt_sync));
      end
   end

   // ==========================================================
   // next state
   // bus timing, write: address and data may be taken at
   // one edge or apart; once both are held the write lands
   // and bvalid rises at the following edge
   // bus timing, read: rvalid rises at the edge that takes
   // the address, with data muxed from that cycle's state
   // the readies are registered, so a new request is taken
   // at the earliest one edge after its response handshake
   // counter: a control write and a prescaler strobe in the
   // same cycle let the write win and the strobe is lost
   // writes never touch the prescaler phase, so the real
   // timeout spreads over up to one prescaler period
   // activation only ever sets here; clearing it needs rst_in
   // triggers are gated by the effective active state, the
   // activation after this cycle's write or hardware mode
   // a trigger while the pulse runs is dropped on purpose,
   // the chip holds the block in reset from the pulse anyway
   // every helper below is given a value on every path so
   // that no latch can form
   always_comb begin
      state_next = state_reg;
      ctrl_write = 1'b0;

      // option straps: two flip-flops before use
      // straps are quasi-static; a change mid-run takes effect
      // two enabled edges later, never in the same cycle
      state_next.opt_meta[wrw_pkg::OPT_HW] = hw_watchdog_opt_in;
      state_next.opt_meta[wrw_pkg::OPT_HALT] = halt_reset_option_in;
      state_next.opt_sync = state_reg.opt_meta;

      // write channels: address and data taken in either order
      case (state_reg.wr_state)
         wrw_pkg::WS_COLLECT: begin
            if (s_axi_awvalid_in && state_reg.awready) begin
               state_next.aw_have = 1'b1;
               state_next.waddr = s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && state_reg.wready) begin
               state_next.w_have = 1'b1;
               state_next.wdata = s_axi_wdata_in;
               state_next.wstrb = s_axi_wstrb_in;
            end
            if (state_reg.aw_have && state_reg.w_have) begin
               state_next.aw_have = 1'b0;
               state_next.w_have = 1'b0;
               state_next.bvalid = 1'b1;
               state_next.wr_state = wrw_pkg::WS_RESP;
               if (reg_hit(state_reg.waddr)) begin
                  state_next.bresp = wrw_pkg::RESP_OKAY;
                  ctrl_write = (state_reg.waddr == wrw_pkg::CTRL_OFFSET) &&
                               state_reg.wstrb[wrw_pkg::STRB_LANE0];
               end else begin
                  state_next.bresp = wrw_pkg::RESP_SLVERR;
               end
            end
         end
         wrw_pkg::WS_RESP: begin
            if (s_axi_bready_in) begin
               state_next.bvalid = 1'b0;
               state_next.wr_state = wrw_pkg::WS_COLLECT;
            end
         end
         default: begin
            state_next.bvalid = 1'b0;
            state_next.wr_state = wrw_pkg::WS_COLLECT;
         end
      endcase
      state_next.awready = (state_next.wr_state == wrw_pkg::WS_COLLECT) &&
                           !state_next.aw_have;
      state_next.wready = (state_next.wr_state == wrw_pkg::WS_COLLECT) &&
                          !state_next.w_have;

      // read channels: one read at a time
      case (state_reg.rd_state)
         wrw_pkg::RS_IDLE: begin
            if (s_axi_arvalid_in && state_reg.arready) begin
               state_next.rvalid = 1'b1;
               state_next.rdata = read_word;
               state_next.rresp = reg_hit(s_axi_araddr_in) ?
                                  wrw_pkg::RESP_OKAY : wrw_pkg::RESP_SLVERR;
               state_next.rd_state = wrw_pkg::RS_DATA;
            end
         end
         wrw_pkg::RS_DATA: begin
            if (s_axi_rready_in) begin
               state_next.rvalid = 1'b0;
               state_next.rd_state = wrw_pkg::RS_IDLE;
            end
         end
         default: begin
            state_next.rvalid = 1'b0;
            state_next.rd_state = wrw_pkg::RS_IDLE;
         end
      endcase
      state_next.arready = (state_next.rd_state == wrw_pkg::RS_IDLE);

      // prescaler: free-running, never cleared by writes
      // wraps at the parameter value; the default gives one
      // strobe per 16384 cycles of the clock
      presc_tick = (state_reg.presc == PRESC_LAST);
      if (presc_tick) begin
         state_next.presc = '0;
      end else begin
         state_next.presc = state_reg.presc + 1'b1;
      end

      // counter: load on write, else step down on every strobe
      // keeps counting while inactive and wraps from zero to
      // the top value
      if (ctrl_write) begin
         state_next.counter = state_reg.wdata[wrw_pkg::CNT_W-1:0];
         state_next.activation_bit = state_reg.activation_bit |
                                     state_reg.wdata[wrw_pkg::ACT_BIT];
      end else if (presc_tick) begin
         state_next.counter = state_reg.counter - wrw_pkg::CNT_ONE;
      end

      // hardware mode overrides the activation bit
      eff_active = state_next.activation_bit |
                   state_reg.opt_sync[wrw_pkg::OPT_HW];

      // reset causes: rollover, forced top-bit clear, halt
      // rollover is checked on the old counter value, so a write
      // landing on the strobe cycle cancels the rollover as well
      // halt is a same-clock strobe from the core, read unsynced
      fire = 1'b0;
      if (eff_active) begin
         if (presc_tick && !ctrl_write &&
             state_reg.counter == wrw_pkg::ROLL_FROM) begin
            fire = 1'b1;
         end
         if (ctrl_write && !state_reg.wdata[wrw_pkg::TOP_BIT]) begin
            fire = 1'b1;
         end
         if (halt_in && state_reg.opt_sync[wrw_pkg::OPT_HALT]) begin
            fire = 1'b1;
         end
      end

      // reset pin follows the pulse timer
      state_next.reset_n = !pulse_busy;
   end

   // ==========================================================
   // state register, frozen while ce_in is low
   // reset restores the inactive image: activation clear,
   // counter at its top value, prescaler phase at zero
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_reg <= STATE_RESET;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // reset pulse timer
   // the timer fixes the pulse length; the pin register
   // follows its busy flag one cycle later, which keeps the
   // request glitch-free and straight from a flip-flop
   wrw_pulse_gen u_pulse (
      .clock_in (clock_in),
      .rst_in (rst_in),
      .ce_in (ce_in),
      .start_in (fire),
      .busy_out (pulse_busy)
   );

   // ==========================================================
   // outputs, all straight from state flip-flops
   // the pin is active low and idles high, also in reset
   // read data and responses hold until their handshake
   assign s_axi_awready_out = state_reg.awready;
   assign s_axi_wready_out = state_reg.wready;
   assign s_axi_bresp_out = state_reg.bresp;
   assign s_axi_bvalid_out = state_reg.bvalid;
   assign s_axi_arready_out = state_reg.arready;
   assign s_axi_rdata_out = state_reg.rdata;
   assign s_axi_rresp_out = state_reg.rresp;
   assign s_axi_rvalid_out = state_reg.rvalid;
   assign wdg_reset_n_out = state_reg.reset_n;

endmodule // wrw_top

// *** verification/wrw_asserts.sv ***
// port-level checker of the windowed reset watchdog
// assumes it is bound onto wrw_top, one clock domain
`timescale 1ns/1ps

module wrw_chk (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // register bus
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // cpu, straps, reset request
   input wire logic halt_in,
   input wire logic hw_watchdog_opt_in,
   input wire logic halt_reset_option_in,
   input wire logic wdg_reset_n_out
);
   // ==========================================================
   // helper logic
   logic aw_w;
   int low_cnt;
   assign aw_w = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   // cycles the reset request has been low
   always_ff @(posedge clock_in) begin
      if (rst_in || wdg_reset_n_out) low_cnt <= 0;
      else low_cnt <= low_cnt + 1;
   end

   // ==========================================================
   // properties
   rst_quiet_a: assert property (@(posedge clock_in)
      rst_in |=> wdg_reset_n_out && !s_axi_bvalid_out && !s_axi_rvalid_out)
      else $error("outputs not idle after reset");
   pulse_len_a: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(wdg_reset_n_out) |-> low_cnt == wrw_pkg::PULSE_CYCLES)
      else $error("reset pulse length wrong");
   b_latency_a: assert property (@(posedge clock_in) disable iff (rst_in)
      aw_w |-> !s_axi_bvalid_out ##2 s_axi_bvalid_out)
      else $error("write response late");
   r_latency_a: assert property (@(posedge clock_in) disable iff (rst_in)
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read data late");
   b_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
      s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   r_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
      s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
   aw_busy_a: assert property (@(posedge clock_in) disable iff (rst_in)
      s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while response pending");
   sw_reset_a: assert property (@(posedge clock_in) disable iff (rst_in)
      aw_w && s_axi_awaddr_in == 8'h00 && s_axi_wstrb_in[0] && s_axi_wdata_in[7:6] == 2'h2
      |-> ##[2:4] !wdg_reset_n_out)
      else $error("software reset missing");
   halt_reset_a: assert property (@(posedge clock_in) disable iff (rst_in)
      halt_in && hw_watchdog_opt_in && halt_reset_option_in && $past(hw_watchdog_opt_in, 3)
      && $past(halt_reset_option_in, 3) |-> ##[1:3] !wdg_reset_n_out)
      else $error("halt reset missing");
endmodule // wrw_chk

bind wrw_top wrw_chk u_chk (.*);

// *** verification/wrw_chip_model.sv ***
// model of the chip reset logic watching the reset request
// assumes the request is sampled on clock_in
`timescale 1ns/1ps

module wrw_chip_model (
   // clock and request
   input wire logic clock_in,
   input wire logic wdg_reset_n_in,
   // last measured low time in cycles
   output logic [15:0] pulse_len_out
);
   // ==========================================================
   // low-time measurement
   logic [15:0] cnt_reg = 16'h0000;
   initial pulse_len_out = 16'h0000;
   // count low cycles, latch the total on release
   always @(posedge clock_in) begin
      if (wdg_reset_n_in === 1'b0) cnt_reg <= cnt_reg + 16'h0001;
      else begin
         if (cnt_reg != 16'h0000) pulse_len_out <= cnt_reg;
         cnt_reg <= 16'h0000;
      end
   end
endmodule // wrw_chip_model

// *** verification/tb_windowed_reset_watchdog.sv ***
// self-checking bench of the windowed reset watchdog
// assumes wrw_top, wrw_chip_model and the bound checker
`timescale 1ns/1ps

module tb_windowed_reset_watchdog;
   // ==========================================================
   // stimulus and observed signals
   logic clk = 0, rst = 1, ce = 1, halt = 0, hw = 0, hopt = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, d, rdata;
   logic [3:0] ws = 4'h0;
   logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic awr, wrdy, bv, arr, rv, wdg;
   logic [1:0] bresp, rresp, r;
   logic [15:0] plen;
   int num_errors = 0, samples_checked = 0, n, c;

   // clock
   always #5 clk = ~clk;

   wrw_top #(.PRESCALE_CYCLES(16)) DUT (
      .clock_in(clk), .rst_in(rst), .ce_in(ce),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .halt_in(halt),
      .hw_watchdog_opt_in(hw), .halt_reset_option_in(hopt), .wdg_reset_n_out(wdg)
   );
   wrw_chip_model chip (.clock_in(clk), .wdg_reset_n_in(wdg), .pulse_len_out(plen));

   // ==========================================================
   // reporting
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
      samples_checked++;
      if ($isunknown(g) || g < lo || g > hi) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h..%h", $time, g, lo, hi);
      end
   endtask
   task automatic hang;
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, 0, 1);
      test_done;
   endtask

   // ==========================================================
   // clocking, reset and bus helpers
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic do_reset;
      @(posedge clk) rst <= 1;
      tick(10);
      rst <= 0;
      tick(2);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int i;
      @(posedge clk);
      awa <= a;
      wd <= v;
      ws <= 4'hf;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
         if (bv) break;
      end
      bre <= 0;
      rs = bresp;
      if (i == 100) hang;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int i;
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rre <= 1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv) break;
      end
      rre <= 0;
      v = rdata;
      rs = rresp;
      if (i == 100) hang;
   endtask
   task automatic wait_low(input int lim, output int k);
      k = 0;
      while (wdg === 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic wait_end;
      int i;
      for (i = 0; i < 4000 && wdg !== 1'b1; i++) @(posedge clk);
      if (i == 4000) hang;
      tick(1);
   endtask
   task automatic pulse_halt;
      @(posedge clk) halt <= 1;
      @(posedge clk) halt <= 0;
   endtask

   // ==========================================================
   // scenarios
   task t_reset;
      rd(8'h00, d, r);
      chk(d, 32'h7f);
      chk(r, wrw_pkg::RESP_OKAY);
      rd(8'h04, d, r);
      chk(d, 32'h0);
      rd(8'h00, d, r);
      c = d[6:0];
      @(posedge clk) ce <= 0;
      tick(48);
      ce <= 1;
      rd(8'h00, d, r);
      chk_rng(c - d[6:0], 0, 1);
   endtask
   task t_free;
      wr(8'h00, 32'h7f, r);
      chk(r, wrw_pkg::RESP_OKAY);
      rd(8'h00, d, r);
      c = d[6:0];
      tick(64);
      rd(8'h00, d, r);
      chk_rng(c - d[6:0], 4, 5);
      wr(8'h00, 32'h41, r);
      wait_low(60, n);
      chk(wdg, 1);
   endtask
   task t_timeout;
      repeat (4) begin
         wr(8'h00, 32'hc2, r);
         tick(10);
         chk(wdg, 1);
      end
      wr(8'h00, 32'hc1, r);
      wait_low(60, n);
      chk_rng(n, 16, 36);
      wr(8'h00, 32'h7f, r);
      rd(8'h00, d, r);
      chk(d[7], 1);
      wait_end;
      chk(plen, wrw_pkg::PULSE_CYCLES);
      do_reset;
      rd(8'h00, d, r);
      chk(d[7], 0);
   endtask
   task t_swrst;
      wr(8'h00, 32'h80, r);
      wait_low(4, n);
      chk_rng(n, 0, 2);
      rd(8'h04, d, r);
      chk(d, 32'h3);
      wait_end;
      do_reset;
   endtask
   task t_hw;
      @(posedge clk) hw <= 1;
      tick(5);
      rd(8'h04, d, r);
      chk(d, 32'h5);
      pulse_halt;
      wait_low(20, n);
      chk(wdg, 1);
      @(posedge clk) hopt <= 1;
      tick(5);
      rd(8'h04, d, r);
      chk(d, 32'hd);
      pulse_halt;
      wait_low(4, n);
      chk_rng(n, 0, 3);
      wait_end;
      hw <= 0;
      hopt <= 0;
      do_reset;
   endtask
   task t_bad;
      rd(8'h08, d, r);
      chk(r, wrw_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h02, 32'hc0, r);
      chk(r, wrw_pkg::RESP_SLVERR);
      rd(8'h00, d, r);
      chk(d[7], 0);
   endtask

   // main sequence
   initial begin
      do_reset;
      t_reset;
      t_free;
      t_timeout;
      t_swrst;
      t_hw;
      t_bad;
      test_done;
   end
endmodule // tb_windowed_reset_watchdog
